// ### hw/usbeps_consts.svh
// register indices, field codes and sizes of the endpoint register set
// assumes: included by bare name from the package and the top module
`ifndef USBEPS_CONSTS_SVH
`define USBEPS_CONSTS_SVH

// ----------------------------------------------------------------
// register indices, byte address is four times the index
// ----------------------------------------------------------------
`define USBEPS_IDX_SHIFT     2
`define USBEPS_IDX_CNT_HUB0  14'h1fcf
`define USBEPS_IDX_CNT_F0    14'h1fcd
`define USBEPS_IDX_CNT_F1    14'h1fcc
`define USBEPS_IDX_CNT_F2    14'h1fcb
`define USBEPS_IDX_CNT_F3    14'h1fca
`define USBEPS_IDX_FIFO_HUB0 14'h1fd7
`define USBEPS_IDX_FIFO_F0   14'h1fd5
`define USBEPS_IDX_FIFO_F1   14'h1fd4
`define USBEPS_IDX_FIFO_F2   14'h1fd3
`define USBEPS_IDX_FIFO_F3   14'h1fd2
`define USBEPS_IDX_STAT_HUB0 14'h1fdf
`define USBEPS_IDX_STAT_F0   14'h1fdd
`define USBEPS_IDX_STAT_F1   14'h1fdc
`define USBEPS_IDX_STAT_F2   14'h1fdb
`define USBEPS_IDX_STAT_F3   14'h1fda
`define USBEPS_IDX_CTL_HUB0  14'h1fa7
`define USBEPS_IDX_CTL_F0    14'h1fa5
`define USBEPS_IDX_CTL_F1    14'h1fa4
`define USBEPS_IDX_CTL_F2    14'h1fa3
`define USBEPS_IDX_CTL_F3    14'h1fa2
`define USBEPS_IDX_CFG_F1    14'h1fe4
`define USBEPS_IDX_CFG_F2    14'h1fe3
`define USBEPS_IDX_CFG_F3    14'h1fe2

// ----------------------------------------------------------------
// sizes, field codes, bus answers
// ----------------------------------------------------------------
`define USBEPS_NUM_EP        5
`define USBEPS_NUM_FEP       3
`define USBEPS_FIRST_FEP     3'h2
`define USBEPS_FIFO_DEPTH    4'h8
`define USBEPS_TYPE_ISO      2'h1
`define USBEPS_STAT_SETUP    4'h4
`define USBEPS_RESP_OKAY     2'h0
`define USBEPS_RESP_SLVERR   2'h2
`define USBEPS_CFG_RSVD      3'h0
`define USBEPS_ACK_RDZERO    4'h0
`define USBEPS_MAP_RSVD      2'h0

`endif

// ### hw/usbeps_pkg.sv
// types shared by the endpoint register set and its packet engine side
// assumes: the constants header sits beside it on the include path
`include "usbeps_consts.svh"

package usbeps_pkg;
	// link side operations, one per cycle
	typedef enum logic [3:0] {
		OP_NONE     = 4'h0,
		OP_PUSH     = 4'h1,
		OP_POP      = 4'h2,
		OP_TOK_IN   = 4'h3,
		OP_TOK_OUT  = 4'h4,
		OP_SETUP_GO = 4'h5,
		OP_SETUP_OK = 4'h6,
		OP_OUT_OK   = 4'h7,
		OP_IN_ACKED = 4'h8,
		OP_IN_SENT  = 4'h9,
		OP_STALLED  = 4'ha
	} usbeps_op_e;

	// handshake chosen for a token
	typedef enum logic [2:0] {
		HS_NONE  = 3'h0,
		HS_ACK   = 3'h1,
		HS_NAK   = 3'h2,
		HS_STALL = 3'h3,
		HS_DATA  = 3'h4
	} usbeps_hs_e;

	typedef struct packed {
		logic [2:0] ep;
		usbeps_op_e op;
		logic [7:0] data;
		logic [5:0] count;
	} usbeps_lreq_s;

	typedef struct packed {
		usbeps_hs_e hs;
		logic       toggle;
		logic       data_vld;
		logic [7:0] data;
	} usbeps_lrsp_s;

	typedef struct packed {
		logic       endpoint_on_bit;
		logic       data_toggle_bit;
		logic       endpoint_in_select;
		logic [1:0] transfer_type_field;
	} usbeps_cfg_s;

	typedef struct packed {
		logic stall_sent;
		logic rx_setup;
		logic rx_out;
		logic tx_done;
	} usbeps_stat_s;

	typedef struct packed {
		logic ctl_read;
		logic data_end;
		logic force_stall;
		logic tx_ready;
	} usbeps_ctl_s;
endpackage

// ### hw/usbeps_top.sv
// endpoint register set: configs, fifo ports, byte counts, status flags
// assumes: an axi4-lite master on one side, a packet engine on the other
//
// The AXI4-Lite register port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
`include "usbeps_consts.svh"

module usbeps_top (
	// clock and reset
	input  wire logic                   clk,
	input  wire logic                   rstn,
	// axi4-lite register slave
	input  wire logic [15:0]            s_axil_awaddr,
	input  wire logic                   s_axil_awvalid,
	output logic                        s_axil_awready,
	input  wire logic [31:0]            s_axil_wdata,
	input  wire logic [3:0]             s_axil_wstrb,
	input  wire logic                   s_axil_wvalid,
	output logic                        s_axil_wready,
	output logic [1:0]                  s_axil_bresp,
	output logic                        s_axil_bvalid,
	input  wire logic                   s_axil_bready,
	input  wire logic [15:0]            s_axil_araddr,
	input  wire logic                   s_axil_arvalid,
	output logic                        s_axil_arready,
	output logic [31:0]                 s_axil_rdata,
	output logic [1:0]                  s_axil_rresp,
	output logic                        s_axil_rvalid,
	input  wire logic                   s_axil_rready,
	// packet engine side
	input  wire usbeps_pkg::usbeps_lreq_s lnk_req,
	output usbeps_pkg::usbeps_lrsp_s     lnk_rsp,
	input  wire logic [5:0]             hub_change_in,
	output logic [7:0]                  hub_change_bitmap,
	output logic [4:0]                  ep_attention
);
	import usbeps_pkg::*;

	// ----------------------------------------------------------------
	// state and register maps
	// ----------------------------------------------------------------
	// ep order: hub ep0, func ep0, func ep1, func ep2, func ep3
	typedef struct packed {
		logic                aw_rdy;
		logic                bvalid;
		logic [1:0]          bresp;
		logic                ar_rdy;
		logic                rvalid;
		logic [1:0]          rresp;
		logic [31:0]         rdata;
		usbeps_cfg_s [2:0]   cfg;
		usbeps_stat_s [4:0]  stat;
		usbeps_ctl_s [4:0]   ctl;
		logic [4:0][5:0]     cnt;
		logic [4:0][7:0][7:0] mem;
		logic [4:0][2:0]     wp;
		logic [4:0][2:0]     rp;
		logic [4:0][3:0]     lvl;
		logic [4:0]          setup_busy;
		usbeps_lrsp_s        rsp;
		logic [7:0]          bitmap;
		logic [4:0]          attn;
	} usbeps_state_s;

	localparam logic [4:0][13:0] CNT_IDX = {`USBEPS_IDX_CNT_F3,
		`USBEPS_IDX_CNT_F2, `USBEPS_IDX_CNT_F1, `USBEPS_IDX_CNT_F0,
		`USBEPS_IDX_CNT_HUB0};
	localparam logic [4:0][13:0] FIFO_IDX = {`USBEPS_IDX_FIFO_F3,
		`USBEPS_IDX_FIFO_F2, `USBEPS_IDX_FIFO_F1, `USBEPS_IDX_FIFO_F0,
		`USBEPS_IDX_FIFO_HUB0};
	localparam logic [4:0][13:0] STAT_IDX = {`USBEPS_IDX_STAT_F3,
		`USBEPS_IDX_STAT_F2, `USBEPS_IDX_STAT_F1, `USBEPS_IDX_STAT_F0,
		`USBEPS_IDX_STAT_HUB0};
	localparam logic [4:0][13:0] CTL_IDX = {`USBEPS_IDX_CTL_F3,
		`USBEPS_IDX_CTL_F2, `USBEPS_IDX_CTL_F1, `USBEPS_IDX_CTL_F0,
		`USBEPS_IDX_CTL_HUB0};
	localparam logic [2:0][13:0] CFG_IDX = {`USBEPS_IDX_CFG_F3,
		`USBEPS_IDX_CFG_F2, `USBEPS_IDX_CFG_F1};

	usbeps_state_s q_ff;
	usbeps_state_s nxt_q;
	logic [13:0]   w_idx;
	logic [13:0]   r_idx;
	logic [7:0]    wd;
	logic          wr_fire;
	logic          rd_fire;

	// master holds valid and payload until the ready cycle
	assign w_idx   = s_axil_awaddr[15:`USBEPS_IDX_SHIFT];
	assign r_idx   = s_axil_araddr[15:`USBEPS_IDX_SHIFT];
	assign wd      = s_axil_wdata[7:0];
	assign wr_fire = q_ff.aw_rdy;
	assign rd_fire = q_ff.ar_rdy;

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		logic [2:0] le;
		logic [1:0] lc;
		logic       ep_ok;
		logic       on;
		logic       ep0;
		logic [2:0] e3;
		le    = lnk_req.ep;
		lc    = 2'(le - `USBEPS_FIRST_FEP);
		ep_ok = (le < 3'(`USBEPS_NUM_EP));
		ep0   = (le < `USBEPS_FIRST_FEP);
		on    = 1'b1;
		e3    = 3'h0;
		nxt_q = q_ff;
		nxt_q.rsp.hs       = HS_NONE;
		nxt_q.rsp.data_vld = 1'b0;

		// bus channels: answers retire first, then new requests
		if (q_ff.bvalid && s_axil_bready)
			nxt_q.bvalid = 1'b0;
		if (q_ff.rvalid && s_axil_rready)
			nxt_q.rvalid = 1'b0;
		if (!q_ff.aw_rdy && !q_ff.bvalid && s_axil_awvalid && s_axil_wvalid)
			nxt_q.aw_rdy = 1'b1;
		if (!q_ff.ar_rdy && !q_ff.rvalid && s_axil_arvalid)
			nxt_q.ar_rdy = 1'b1;
		if (wr_fire) begin
			nxt_q.aw_rdy = 1'b0;
			nxt_q.bvalid = 1'b1;
			nxt_q.bresp  = `USBEPS_RESP_SLVERR;
		end
		if (rd_fire) begin
			nxt_q.ar_rdy = 1'b0;
			nxt_q.rvalid = 1'b1;
			nxt_q.rresp  = `USBEPS_RESP_SLVERR;
			nxt_q.rdata  = 32'h0000_0000;
		end

		// firmware writes; status is read only, write just answers okay
		for (int e = 0; e < `USBEPS_NUM_EP; e++) begin
			e3 = 3'(e);
			if (wr_fire && w_idx == STAT_IDX[e])
				nxt_q.bresp = `USBEPS_RESP_OKAY;
			if (wr_fire && w_idx == CNT_IDX[e]) begin
				nxt_q.bresp = `USBEPS_RESP_OKAY;
				if (s_axil_wstrb[0])
					nxt_q.cnt[e] = {q_ff.cnt[e][5], wd[4:0]};
			end
			if (wr_fire && w_idx == FIFO_IDX[e]) begin
				nxt_q.bresp = `USBEPS_RESP_OKAY;
				// a full fifo drops the byte, eight is the packet limit
				if (s_axil_wstrb[0] && q_ff.lvl[e] != `USBEPS_FIFO_DEPTH) begin
					nxt_q.mem[e][q_ff.wp[e]] = wd;
					nxt_q.wp[e]  = 3'(q_ff.wp[e] + 3'h1);
					nxt_q.lvl[e] = 4'(q_ff.lvl[e] + 4'h1);
				end
			end
			if (wr_fire && w_idx == CTL_IDX[e]) begin
				nxt_q.bresp = `USBEPS_RESP_OKAY;
				if (s_axil_wstrb[0]) begin
					nxt_q.ctl[e] = wd[7:4];
					// direction bit exists on control endpoints only
					nxt_q.ctl[e].ctl_read = (e3 < `USBEPS_FIRST_FEP) & wd[7];
					nxt_q.stat[e] = q_ff.stat[e] & ~wd[3:0];
				end
			end
		end
		for (int c = 0; c < `USBEPS_NUM_FEP; c++) begin
			if (wr_fire && w_idx == CFG_IDX[c]) begin
				nxt_q.bresp = `USBEPS_RESP_OKAY;
				if (s_axil_wstrb[0])
					nxt_q.cfg[c] = {wd[7], wd[3:0]};
			end
		end

		// firmware reads; data port read pops a byte
		for (int e = 0; e < `USBEPS_NUM_EP; e++) begin
			if (rd_fire && r_idx == CNT_IDX[e]) begin
				nxt_q.rresp = `USBEPS_RESP_OKAY;
				nxt_q.rdata = 32'(q_ff.cnt[e]);
			end
			if (rd_fire && r_idx == STAT_IDX[e]) begin
				nxt_q.rresp = `USBEPS_RESP_OKAY;
				nxt_q.rdata = 32'(q_ff.stat[e]);
			end
			if (rd_fire && r_idx == CTL_IDX[e]) begin
				nxt_q.rresp = `USBEPS_RESP_OKAY;
				nxt_q.rdata = 32'({q_ff.ctl[e], `USBEPS_ACK_RDZERO});
			end
			if (rd_fire && r_idx == FIFO_IDX[e]) begin
				nxt_q.rresp = `USBEPS_RESP_OKAY;
				// an empty fifo reads zero and stays empty
				if (nxt_q.lvl[e] != 4'h0) begin
					nxt_q.rdata  = 32'(q_ff.mem[e][q_ff.rp[e]]);
					nxt_q.rp[e]  = 3'(q_ff.rp[e] + 3'h1);
					nxt_q.lvl[e] = 4'(nxt_q.lvl[e] - 4'h1);
				end
			end
		end
		for (int c = 0; c < `USBEPS_NUM_FEP; c++) begin
			if (rd_fire && r_idx == CFG_IDX[c]) begin
				nxt_q.rresp = `USBEPS_RESP_OKAY;
				nxt_q.rdata = 32'({q_ff.cfg[c].endpoint_on_bit,
					`USBEPS_CFG_RSVD, q_ff.cfg[c][3:0]});
			end
		end

		// packet engine events land last so a set beats a same-cycle ack
		if (ep_ok && !ep0)
			on = q_ff.cfg[lc].endpoint_on_bit;
		if (ep_ok && on) begin
			unique case (lnk_req.op)
				OP_NONE: begin
				end
				OP_TOK_IN: begin
					nxt_q.rsp.toggle = !ep0 && q_ff.cfg[lc].data_toggle_bit;
					if (q_ff.ctl[le].force_stall)
						nxt_q.rsp.hs = HS_STALL;
					else if (q_ff.ctl[le].tx_ready)
						nxt_q.rsp.hs = HS_DATA;
					// zero length status in after a write or no data stage
					else if (ep0 && q_ff.ctl[le].data_end && !q_ff.ctl[le].ctl_read)
						nxt_q.rsp.hs = HS_DATA;
					else
						nxt_q.rsp.hs = HS_NAK;
				end
				OP_TOK_OUT: begin
					nxt_q.rsp.toggle = !ep0 && q_ff.cfg[lc].data_toggle_bit;
					if (q_ff.ctl[le].force_stall)
						nxt_q.rsp.hs = HS_STALL;
					else if (q_ff.stat[le].rx_out)
						nxt_q.rsp.hs = HS_NAK;
					// status out of a control read waits for done ack
					else if (ep0 && q_ff.ctl[le].ctl_read && q_ff.stat[le].tx_done)
						nxt_q.rsp.hs = HS_NAK;
					else
						nxt_q.rsp.hs = HS_ACK;
				end
				OP_PUSH: begin
					// pending data is never overwritten outside a setup
					if ((q_ff.setup_busy[le] || (!q_ff.stat[le].rx_out &&
						!q_ff.stat[le].rx_setup)) &&
						nxt_q.lvl[le] != `USBEPS_FIFO_DEPTH) begin
						nxt_q.mem[le][nxt_q.wp[le]] = lnk_req.data;
						nxt_q.wp[le]  = 3'(nxt_q.wp[le] + 3'h1);
						nxt_q.lvl[le] = 4'(nxt_q.lvl[le] + 4'h1);
					end
				end
				OP_POP: begin
					nxt_q.rsp.data_vld = 1'b1;
					nxt_q.rsp.data     = 8'h00;
					if (nxt_q.lvl[le] != 4'h0) begin
						nxt_q.rsp.data = nxt_q.mem[le][nxt_q.rp[le]];
						nxt_q.rp[le]   = 3'(nxt_q.rp[le] + 3'h1);
						nxt_q.lvl[le]  = 4'(nxt_q.lvl[le] - 4'h1);
					end
				end
				OP_SETUP_GO: begin
					// early setup discards whatever the fifo held
					if (ep0) begin
						nxt_q.wp[le]  = 3'h0;
						nxt_q.rp[le]  = 3'h0;
						nxt_q.lvl[le] = 4'h0;
						nxt_q.setup_busy[le] = 1'b1;
					end
				end
				OP_SETUP_OK: begin
					if (ep0) begin
						nxt_q.stat[le] = `USBEPS_STAT_SETUP;
						nxt_q.ctl[le].data_end = 1'b0;
						nxt_q.setup_busy[le]   = 1'b0;
						nxt_q.cnt[le] = lnk_req.count;
					end
				end
				OP_OUT_OK: begin
					nxt_q.stat[le].rx_out = 1'b1;
					nxt_q.cnt[le] = lnk_req.count;
					if (!ep0)
						nxt_q.cfg[lc].data_toggle_bit =
							!q_ff.cfg[lc].data_toggle_bit;
				end
				OP_IN_ACKED: begin
					nxt_q.ctl[le].tx_ready = 1'b0;
					nxt_q.stat[le].tx_done = 1'b1;
					if (!ep0)
						nxt_q.cfg[lc].data_toggle_bit =
							!q_ff.cfg[lc].data_toggle_bit;
				end
				OP_IN_SENT: begin
					// iso has no handshake, so sending alone frees the fifo
					if (!ep0 && q_ff.cfg[lc].transfer_type_field ==
						`USBEPS_TYPE_ISO) begin
						nxt_q.ctl[le].tx_ready = 1'b0;
						nxt_q.stat[le].tx_done = 1'b1;
					end
				end
				OP_STALLED: begin
					nxt_q.stat[le].stall_sent = 1'b1;
				end
				default: begin
				end
			endcase
		end

		// attention level per endpoint for the interrupt controller
		for (int e = 0; e < `USBEPS_NUM_EP; e++)
			nxt_q.attn[e] = |nxt_q.stat[e];
		nxt_q.bitmap = {`USBEPS_MAP_RSVD, hub_change_in};
	end

	// ----------------------------------------------------------------
	// state register
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			q_ff <= '0;
		end else begin
			q_ff <= nxt_q;
		end
	end

	// outputs straight from the state register
	assign s_axil_awready    = q_ff.aw_rdy;
	assign s_axil_wready     = q_ff.aw_rdy;
	assign s_axil_bvalid     = q_ff.bvalid;
	assign s_axil_bresp      = q_ff.bresp;
	assign s_axil_arready    = q_ff.ar_rdy;
	assign s_axil_rvalid     = q_ff.rvalid;
	assign s_axil_rresp      = q_ff.rresp;
	assign s_axil_rdata      = q_ff.rdata;
	assign lnk_rsp           = q_ff.rsp;
	assign hub_change_bitmap = q_ff.bitmap;
	assign ep_attention      = q_ff.attn;

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	sequence s_setup_done;
		lnk_req.op == OP_SETUP_OK && lnk_req.ep == 3'h1;
	endsequence
	property p_setup_clr;
		s_setup_done |=> q_ff.stat[1] == `USBEPS_STAT_SETUP;
	endproperty
	a_setup_clr: assert property (p_setup_clr)
		else $error("setup did not leave only the setup flag");

	property p_bitmap;
		##1 hub_change_bitmap == {2'b00, $past(hub_change_in)};
	endproperty
	a_bitmap: assert property (p_bitmap)
		else $error("change bitmap does not follow hub changes");

	property p_out_nak;
		(lnk_req.op == OP_TOK_OUT && lnk_req.ep == 3'h2 &&
			q_ff.cfg[0].endpoint_on_bit && q_ff.stat[2].rx_out &&
			!q_ff.ctl[2].force_stall) |=> lnk_rsp.hs == HS_NAK;
	endproperty
	a_out_nak: assert property (p_out_nak)
		else $error("out token not refused while data pending");

	property p_stall;
		((lnk_req.op == OP_TOK_IN || lnk_req.op == OP_TOK_OUT) &&
			lnk_req.ep == 3'h2 && q_ff.cfg[0].endpoint_on_bit &&
			q_ff.ctl[2].force_stall) |=> lnk_rsp.hs == HS_STALL;
	endproperty
	a_stall: assert property (p_stall)
		else $error("halt request did not stall the token");

	// attention is registered from the next state, so it rises with the flag
	property p_stall_flag;
		(lnk_req.op == OP_STALLED && lnk_req.ep == 3'h2 &&
			q_ff.cfg[0].endpoint_on_bit)
			|=> q_ff.stat[2].stall_sent && ep_attention[2];
	endproperty
	a_stall_flag: assert property (p_stall_flag)
		else $error("stall sent flag not raised");

	property p_tx_done;
		(lnk_req.op == OP_IN_ACKED && lnk_req.ep == 3'h0)
			|=> q_ff.stat[0].tx_done && !q_ff.ctl[0].tx_ready;
	endproperty
	a_tx_done: assert property (p_tx_done)
		else $error("acked in did not complete the transmit");

	property p_toggle;
		(lnk_req.op == OP_OUT_OK && lnk_req.ep == 3'h2 &&
			q_ff.cfg[0].endpoint_on_bit) |=> q_ff.cfg[0].data_toggle_bit
			!= $past(q_ff.cfg[0].data_toggle_bit);
	endproperty
	a_toggle: assert property (p_toggle)
		else $error("data toggle did not flip");

	property p_no_overwrite;
		(lnk_req.op == OP_PUSH && lnk_req.ep == 3'h2 &&
			q_ff.stat[2].rx_out && !q_ff.setup_busy[2] &&
			!rd_fire && !wr_fire)
			|=> $stable(q_ff.lvl[2]) && $stable(q_ff.wp[2]);
	endproperty
	a_no_overwrite: assert property (p_no_overwrite)
		else $error("pending fifo data was overwritten");
endmodule

`default_nettype wire

// ### testbench/usbeps_host.sv
// host side model: issues tokens and data packets on the link port
// assumes: one clock, the block takes one link op at each rising edge
`timescale 1ns/1ps
`default_nettype none

module usbeps_host (
	// clock and reset
	input  wire logic                      clk,
	input  wire logic                      rstn,
	// link port
	output var usbeps_pkg::usbeps_lreq_s   lnk_req,
	input  wire usbeps_pkg::usbeps_lrsp_s  lnk_rsp
);
	import usbeps_pkg::*;

	// ----------------------------------------------------------------
	// single op and packet framing
	// ----------------------------------------------------------------
	int gap = 0; // idle edges before each op, to play a slow host

	initial lnk_req = '0;

	// answer is sampled one edge after the op was taken
	task automatic op(input logic [2:0] ep, input usbeps_op_e o,
		input logic [7:0] dt, input logic [5:0] n, output usbeps_lrsp_s r);
		repeat (gap) @(posedge clk);
		@(posedge clk);
		lnk_req <= '{ep: ep, op: o, data: dt, count: n};
		@(posedge clk);
		lnk_req.op <= OP_NONE;
		lnk_req.data <= ~dt; // released bus never shows the last byte
		@(posedge clk);
		r = lnk_rsp;
	endtask

	// bytes then completion; count carries the two crc bytes
	task automatic pkt(input logic [2:0] ep, input usbeps_op_e fin,
		input logic [7:0] b[$]);
		usbeps_lrsp_s r;
		if (fin == OP_SETUP_OK) op(ep, OP_SETUP_GO, 8'h00, 6'h00, r);
		foreach (b[i]) op(ep, OP_PUSH, b[i], 6'h00, r);
		op(ep, fin, 8'h00, 6'(b.size() + 2), r);
	endtask
endmodule
`default_nettype wire

// ### testbench/tb_top.sv
// endpoint register set bench: axi4-lite firmware side, host model on link
// assumes: design package and constants header on the include path
`timescale 1ns/1ps
`default_nettype none
`include "usbeps_consts.svh"

module tb_top;
	import usbeps_pkg::*;

	// ----------------------------------------------------------------
	// signals
	// ----------------------------------------------------------------
	logic                clk, rstn;
	logic [15:0]         s_axil_awaddr, s_axil_araddr;
	logic [31:0]         s_axil_wdata, s_axil_rdata, d;
	logic [3:0]          s_axil_wstrb;
	logic [1:0]          s_axil_bresp, s_axil_rresp, wresp_q, rresp_q;
	logic                s_axil_awvalid, s_axil_awready, s_axil_wvalid;
	logic                s_axil_wready, s_axil_bvalid, s_axil_bready;
	logic                s_axil_arvalid, s_axil_arready, s_axil_rvalid;
	logic                s_axil_rready;
	usbeps_lreq_s        lnk_req;
	usbeps_lrsp_s        lnk_rsp, r;
	logic [5:0]          hub_change_in;
	logic [7:0]          hub_change_bitmap, q[$];
	logic [4:0]          ep_attention;
	int                  mismatches = 0, n_checks = 0;
	logic [13:0]         rst_idx [12] = '{`USBEPS_IDX_CNT_HUB0,
		`USBEPS_IDX_CNT_F0, `USBEPS_IDX_CNT_F1, `USBEPS_IDX_CNT_F2,
		`USBEPS_IDX_CNT_F3, `USBEPS_IDX_STAT_HUB0, `USBEPS_IDX_STAT_F0,
		`USBEPS_IDX_CFG_F1, `USBEPS_IDX_CFG_F2, `USBEPS_IDX_CFG_F3,
		`USBEPS_IDX_CTL_HUB0, `USBEPS_IDX_CTL_F0};

	usbeps_top dut (.clk, .rstn, .s_axil_awaddr, .s_axil_awvalid,
		.s_axil_awready, .s_axil_wdata, .s_axil_wstrb, .s_axil_wvalid,
		.s_axil_wready, .s_axil_bresp, .s_axil_bvalid, .s_axil_bready,
		.s_axil_araddr, .s_axil_arvalid, .s_axil_arready, .s_axil_rdata,
		.s_axil_rresp, .s_axil_rvalid, .s_axil_rready, .lnk_req, .lnk_rsp,
		.hub_change_in, .hub_change_bitmap, .ep_attention);
	usbeps_host host (.clk, .rstn, .lnk_req, .lnk_rsp);

	// ----------------------------------------------------------------
	// bus tasks and checking
	// ----------------------------------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] %0t got %h want %h", $time, got, exp);
		end
	endtask

	// address and data offered together, each dropped once taken
	task automatic wr(input logic [13:0] i, input logic [7:0] v);
		@(posedge clk);
		s_axil_awaddr <= {i, 2'b00};
		s_axil_wdata <= {24'h0, v};
		s_axil_awvalid <= 1'b1;
		s_axil_wvalid <= 1'b1;
		s_axil_bready <= 1'b1;
		do begin
			@(posedge clk);
			if (s_axil_awready) s_axil_awvalid <= 1'b0;
			if (s_axil_wready) s_axil_wvalid <= 1'b0;
		end while (!s_axil_bvalid);
		s_axil_bready <= 1'b0;
		wresp_q = s_axil_bresp;
	endtask

	task automatic rd(input logic [13:0] i, output logic [31:0] v);
		@(posedge clk);
		s_axil_araddr <= {i, 2'b00};
		s_axil_arvalid <= 1'b1;
		s_axil_rready <= 1'b1;
		do begin
			@(posedge clk);
			if (s_axil_arready) s_axil_arvalid <= 1'b0;
		end while (!s_axil_rvalid);
		s_axil_rready <= 1'b0;
		v = s_axil_rdata;
		rresp_q = s_axil_rresp;
	endtask

	task automatic rc(input logic [13:0] i, input logic [7:0] e);
		logic [31:0] v;
		rd(i, v);
		chk(v, {24'h0, e});
	endtask

	task automatic done(input string s);
		$display("test %s done", s);
	endtask

	task automatic summarize;
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// clock, watchdog, tests
	// ----------------------------------------------------------------
	// 25 mhz core clock
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	// whole run is a few hundred edges, this is far beyond it
	initial begin
		repeat (20000) @(posedge clk);
		mismatches++;
		summarize();
	end

	// test sequence
	initial begin
		rstn = 1'b0;
		{s_axil_awaddr, s_axil_araddr, s_axil_wdata} = '0;
		{s_axil_awvalid, s_axil_wvalid, s_axil_bready} = '0;
		{s_axil_arvalid, s_axil_rready} = '0;
		s_axil_wstrb = 4'hf;
		hub_change_in = 6'h00;
		repeat (4) @(posedge clk);
		rstn <= 1'b1;
		foreach (rst_idx[k]) rc(rst_idx[k], 8'h00);
		done("reset");
		// types 1 to 3 in both directions, reserved bits written high
		for (int t = 1; t < 4; t++)
			for (int v = 0; v < 2; v++) begin
				wr(`USBEPS_IDX_CFG_F3, 8'hf0 | 8'(v * 4 + t));
				rc(`USBEPS_IDX_CFG_F3, 8'h80 | 8'(v * 4 + t));
			end
		wr(`USBEPS_IDX_CFG_F3, 8'h00);
		host.op(3'h4, OP_TOK_IN, 8'h00, 6'h00, r);
		chk(32'(r.hs), 32'(HS_NONE));
		wr(`USBEPS_IDX_CNT_F1, 8'hff);
		rc(`USBEPS_IDX_CNT_F1, 8'h1f);
		chk(32'(wresp_q), 32'(`USBEPS_RESP_OKAY));
		chk(32'(rresp_q), 32'(`USBEPS_RESP_OKAY));
		done("config");
		// ninth byte finds the fifo full and is dropped
		for (int k = 0; k < 9; k++) wr(`USBEPS_IDX_FIFO_F0, 8'(8'h40 + k));
		for (int k = 0; k < 9; k++)
			rc(`USBEPS_IDX_FIFO_F0, k < 8 ? 8'(8'h40 + k) : 8'h00);
		done("fifo");
		wr(`USBEPS_IDX_CFG_F1, 8'h82);
		q = {8'ha1, 8'hb2, 8'hc3};
		host.pkt(3'h2, OP_OUT_OK, q);
		rc(`USBEPS_IDX_STAT_F1, 8'h02);
		chk(32'(ep_attention[2]), 32'h1);
		rc(`USBEPS_IDX_CNT_F1, 8'h05);
		host.op(3'h2, OP_TOK_OUT, 8'h00, 6'h00, r);
		chk(32'(r.hs), 32'(HS_NAK));
		host.op(3'h2, OP_PUSH, 8'hee, 6'h00, r);
		foreach (q[k]) rc(`USBEPS_IDX_FIFO_F1, q[k]);
		rc(`USBEPS_IDX_FIFO_F1, 8'h00);
		wr(`USBEPS_IDX_CTL_F1, 8'h02);
		rc(`USBEPS_IDX_STAT_F1, 8'h00);
		rc(`USBEPS_IDX_CTL_F1, 8'h00);
		host.gap = 3;
		host.op(3'h2, OP_TOK_OUT, 8'h00, 6'h00, r);
		chk(32'(r.hs), 32'(HS_ACK));
		host.gap = 0;
		done("out");
		wr(`USBEPS_IDX_CFG_F2, 8'h86);
		wr(`USBEPS_IDX_FIFO_F2, 8'h5a);
		wr(`USBEPS_IDX_CTL_F2, 8'h10);
		host.op(3'h3, OP_TOK_IN, 8'h00, 6'h00, r);
		chk(32'({r.hs, r.toggle}), 32'({HS_DATA, 1'b0}));
		host.op(3'h3, OP_POP, 8'h00, 6'h00, r);
		chk(32'({r.data_vld, r.data}), 32'h15a);
		host.op(3'h3, OP_IN_ACKED, 8'h00, 6'h00, r);
		rc(`USBEPS_IDX_STAT_F2, 8'h01);
		rc(`USBEPS_IDX_CTL_F2, 8'h00);
		rc(`USBEPS_IDX_CFG_F2, 8'h8e);
		host.op(3'h3, OP_TOK_IN, 8'h00, 6'h00, r);
		chk(32'({r.hs, r.toggle}), 32'({HS_NAK, 1'b1}));
		wr(`USBEPS_IDX_CTL_F2, 8'h01);
		rc(`USBEPS_IDX_STAT_F2, 8'h00);
		// iso: ready drops once sent, with no acknowledge
		wr(`USBEPS_IDX_CFG_F2, 8'h85);
		wr(`USBEPS_IDX_CTL_F2, 8'h10);
		host.op(3'h3, OP_TOK_IN, 8'h00, 6'h00, r);
		chk(32'(r.hs), 32'(HS_DATA));
		host.op(3'h3, OP_IN_SENT, 8'h00, 6'h00, r);
		rc(`USBEPS_IDX_CTL_F2, 8'h00);
		rc(`USBEPS_IDX_STAT_F2, 8'h01);
		done("in");
		wr(`USBEPS_IDX_CTL_F1, 8'h20);
		host.op(3'h2, OP_TOK_OUT, 8'h00, 6'h00, r);
		chk(32'(r.hs), 32'(HS_STALL));
		host.op(3'h2, OP_STALLED, 8'h00, 6'h00, r);
		rc(`USBEPS_IDX_STAT_F1, 8'h08);
		wr(`USBEPS_IDX_CTL_F1, 8'h08);
		rc(`USBEPS_IDX_STAT_F1, 8'h00);
		done("stall");
		// zero-length status out, then an early setup over it
		q = {};
		host.pkt(3'h1, OP_OUT_OK, q);
		rc(`USBEPS_IDX_STAT_F0, 8'h02);
		q = {8'h80, 8'h06, 8'h00, 8'h01, 8'h00, 8'h00, 8'h40, 8'h00};
		host.pkt(3'h1, OP_SETUP_OK, q);
		rc(`USBEPS_IDX_STAT_F0, 8'h04);
		rc(`USBEPS_IDX_CNT_F0, 8'h0a);
		foreach (q[k]) rc(`USBEPS_IDX_FIFO_F0, q[k]);
		wr(`USBEPS_IDX_CTL_F0, 8'h04);
		rc(`USBEPS_IDX_STAT_F0, 8'h00);
		done("setup");
		wr(`USBEPS_IDX_CTL_HUB0, 8'h90);
		host.op(3'h0, OP_TOK_IN, 8'h00, 6'h00, r);
		chk(32'(r.hs), 32'(HS_DATA));
		host.op(3'h0, OP_IN_ACKED, 8'h00, 6'h00, r);
		rc(`USBEPS_IDX_STAT_HUB0, 8'h01);
		host.op(3'h0, OP_TOK_OUT, 8'h00, 6'h00, r);
		chk(32'(r.hs), 32'(HS_NAK));
		wr(`USBEPS_IDX_CTL_HUB0, 8'h81);
		host.op(3'h0, OP_TOK_OUT, 8'h00, 6'h00, r);
		chk(32'(r.hs), 32'(HS_ACK));
		rc(`USBEPS_IDX_CTL_HUB0, 8'h80);
		wr(`USBEPS_IDX_CTL_HUB0, 8'h40);
		host.op(3'h0, OP_TOK_IN, 8'h00, 6'h00, r);
		chk(32'(r.hs), 32'(HS_DATA));
		done("control");
		hub_change_in <= 6'h2b;
		repeat (2) @(posedge clk);
		chk(32'(hub_change_bitmap), 32'h2b);
		hub_change_in <= 6'h3f;
		repeat (2) @(posedge clk);
		chk(32'(hub_change_bitmap), 32'h3f);
		rd(14'h0000, d);
		chk(d, 32'h0);
		chk(32'(rresp_q), 32'(`USBEPS_RESP_SLVERR));
		wr(14'h0001, 8'hff);
		chk(32'(wresp_q), 32'(`USBEPS_RESP_SLVERR));
		done("bitmap");
		summarize();
	end
endmodule
`default_nettype wire
